// >>> design/lag_hash.sv
`timescale 1ns/10ps
`include "mlf_defines.svh"
module lag_hash (
   // Flow fields and enables
   input wire logic [47:0] smac,
   input wire logic [47:0] dmac,
   input wire logic [31:0] sip,
   input wire logic [31:0] dip,
   input wire logic [15:0] sport,
   input wire logic [15:0] dport,
   input wire logic ip4,
   input wire logic l4,
   input wire mlf_pkg::hsel_t en,
   // Hash out
   lag_pick_if.hsh pk
);
   logic [191:0] key;

   // Disabled or absent fields fold in as zero, so one flow keeps one code.
   assign key = {en[`H_SMAC] ? smac : 48'h0, en[`H_DMAC] ? dmac : 48'h0,
      (en[`H_SIP] && ip4) ? sip : 32'h0, (en[`H_DIP] && ip4) ? dip : 32'h0,
      (en[`H_SPORT] && l4) ? sport : 16'h0, (en[`H_DPORT] && l4) ? dport : 16'h0};

   // Byte-wise XOR fold; cheap and purely a function of the key.
   always_comb begin
      pk.hash = 8'h00;
      for (int i = 0; i < 24; i++) begin
         pk.hash = pk.hash ^ key[8*i+:8];
      end
   end
endmodule

// >>> design/lag_pick.sv
`timescale 1ns/10ps
module lag_pick #(parameter int N = 12, parameter int G = 5) (
   // Clock and reset for checks only
   input wire logic clk,
   input wire logic rst_n,
   // Selection carrier
   lag_pick_if.sel pk
);
   for (genvar g = 0; g < G; g++) begin : grp
      logic [4:0] cnt;
      logic [7:0] k;

      // Ports past the active limit stay standby and fill in on a member failure.
      always_comb begin
         cnt = 5'h00;
         pk.act[g] = '0;
         for (int i = 0; i < N; i++) begin
            if (pk.mem[g][i] && pk.link[i] && cnt < {1'b0, pk.limit[g]}) begin
               pk.act[g][i] = 1'b1;
               cnt = cnt + 5'h01;
            end
         end
      end

      // Modulo of the hash over the active members picks the egress port.
      assign k = (cnt == 5'h00) ? 8'h00 : pk.hash % {3'h0, cnt};

      // Pick the k-th active member in port order.
      always_comb begin
         logic [7:0] m;
         m = 8'h00;
         pk.pick[g] = '0;
         for (int i = 0; i < N; i++) begin
            if (pk.act[g][i]) begin
               if (m == k) begin
                  pk.pick[g][i] = 1'b1;
               end
               m = m + 8'h01;
            end
         end
      end

      property p_pick_ok;
         @(posedge clk) disable iff (!rst_n)
         (|pk.act[g]) |-> $onehot(pk.pick[g]) && ((pk.pick[g] & ~pk.act[g]) == '0);
      endproperty
      a_pick_ok: assert property (p_pick_ok) else $error("pick not an active member");
   end
endmodule

// >>> design/lag_pick_if.sv
`timescale 1ns/10ps
interface lag_pick_if #(parameter int N = 12, parameter int G = 5);
   mlf_pkg::hash_t hash;
   logic [N-1:0] mem [G];
   logic [N-1:0] link;
   logic [3:0] limit [G];
   logic [N-1:0] act [G];
   logic [N-1:0] pick [G];
   modport hsh (output hash);
   modport sel (input hash, mem, link, limit, output act, pick);
   modport top (output mem, link, limit, input hash, act, pick);
endinterface

// >>> design/mirror_lag_fwd.sv
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "mlf_defines.svh"
// Operation
// - Frames received on an ingress-mirrored port are copied to the mirror destination.
// - Frames sent on an egress-mirrored port are copied to the mirror destination.
// - Each session enables local and remote mirroring independently.
// - Remote mirroring VLAN is configurable and resets to 200.
// - Reflector port carries only mirrored traffic while remote mirroring is on.
// - A shut-down port is refused as reflector.
// - A shut-down reflector stops remote mirror copies.
// - Reflector needs source type, copper, no learning and no spanning tree.
// - The mirror destination never mirrors its own transmit frames.
// - An aggregated group forwards as one logical port.
// - Group members share one speed and run full duplex.
// - A port belongs to at most one group.
// - Group members cannot be mirror sources or mirror destination.
// - Group members join or leave a VLAN together.
// - One flow always leaves on one member port.
// - Hash uses MACs, IPv4 addresses and L4 ports, each enabled separately.
// - A group holds at most ten members.
// - Up to five groups are supported.
// - Members beyond the active limit wait in standby and replace failures.
module mirror_lag_fwd #(
   parameter int N = 12,
   parameter int G = `NGRP_DEF,
   parameter int MAXM = `MAXM_DEF
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Port state from the MAC layer
   input wire logic [N-1:0] PORT_LINK,
   input wire logic [N-1:0] PORT_FDX,
   input wire logic [N-1:0] PORT_COPPER,
   input wire logic [N-1:0] PORT_LEARN,
   input wire logic [N-1:0] PORT_STP,
   input wire logic [2*N-1:0] PORT_SPEED,
   // Frame descriptor in
   input wire logic FRM_VALID,
   output logic FRM_READY,
   input wire mlf_pkg::pidx_t FRM_SRC,
   input wire logic [N-1:0] FRM_DST,
   input wire logic [47:0] FRM_SMAC,
   input wire logic [47:0] FRM_DMAC,
   input wire logic [31:0] FRM_SIP,
   input wire logic [31:0] FRM_DIP,
   input wire logic [15:0] FRM_SPORT,
   input wire logic [15:0] FRM_DPORT,
   input wire logic FRM_IP4,
   input wire logic FRM_L4,
   // Forwarding decision out
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic [N-1:0] OUT_DST,
   output logic [N-1:0] OUT_COPY,
   output logic OUT_TAG,
   output mlf_pkg::vid_t OUT_VID
);
   localparam logic [N-1:0] ONE = {{(N-1){1'b0}}, 1'b1};

   logic loc_q, rem_q, srct_q, refused_q;
   mlf_pkg::pidx_t refl_q, dest_q;
   mlf_pkg::vid_t vid_q;
   mlf_pkg::hsel_t hen_q;
   logic [N-1:0] rx_q, tx_q, admin_q, vlan_q;
   logic [N-1:0] lag_q [G];
   logic [3:0] lim_q [G];

   lag_pick_if #(.N(N), .G(G)) pk ();

   function automatic logic rok(input mlf_pkg::pidx_t p);
      rok = ({28'h0, p} < N) && admin_q[p] && PORT_COPPER[p] && !PORT_LEARN[p] && !PORT_STP[p];
   endfunction

   // APB phases and address decode.
   wire setup = PSEL && !PENABLE;
   wire acc_ph = PSEL && PENABLE;
   wire wr = acc_ph && PWRITE;
   wire [7:0] lag_off = PADDR - `A_LAG_BASE;
   wire [2:0] lag_idx = lag_off[4:2];
   wire hit_lag = (PADDR >= `A_LAG_BASE) && ({24'h0, lag_off} < 32'(4 * G))
      && (PADDR[1:0] == 2'h0);
   wire hit_ctrl = PADDR == `A_MIR_CTRL;
   wire hit_vid = PADDR == `A_RMIR_VID;
   wire hit_rx = PADDR == `A_MIR_RX;
   wire hit_tx = PADDR == `A_MIR_TX;
   wire hit_adm = PADDR == `A_ADMIN;
   wire hit_hen = PADDR == `A_HASH_EN;
   wire hit_lim = PADDR == `A_ACT_LIM;
   wire hit_st = PADDR == `A_STATUS;
   wire hit_vl = PADDR == `A_VLAN;
   wire unmapped = !(hit_lag || hit_ctrl || hit_vid || hit_rx || hit_tx || hit_adm
      || hit_hen || hit_lim || hit_st || hit_vl);

   // Union of every group, and of every group but the one addressed.
   logic [N-1:0] lag_all, lag_oth;
   always_comb begin
      lag_all = '0;
      lag_oth = '0;
      for (int g = 0; g < G; g++) begin
         lag_all = lag_all | lag_q[g];
         if (lag_idx != 3'(g)) begin
            lag_oth = lag_oth | lag_q[g];
         end
      end
   end

   // Speeds present among a proposed member set.
   wire [N-1:0] wm = PWDATA[N-1:0];
   logic [3:0] spd_seen;
   always_comb begin
      spd_seen = 4'h0;
      for (int i = 0; i < N; i++) begin
         if (wm[i]) begin
            spd_seen[PORT_SPEED[2*i+:2]] = 1'b1;
         end
      end
   end

   // Configuration checks; a refused write leaves the registers untouched.
   wire [3:0] w_refl = PWDATA[`F_REFL+:4];
   wire [3:0] w_dest = PWDATA[`F_DEST+:4];
   wire [N-1:0] mir_all = rx_q | tx_q | (ONE << dest_q);
   wire bad_ctrl = (PWDATA[`F_REM] && (!PWDATA[`F_SRC] || !rok(w_refl)))
      || ({28'h0, w_dest} >= N) || |(lag_all & (ONE << w_dest));
   wire bad_src = |(wm & lag_all);
   wire bad_lag = |(wm & lag_oth)
      || ($countones(wm) > MAXM)
      || |(wm & mir_all)
      || ($countones(spd_seen) > 1) || |(wm & ~PORT_FDX);
   wire refuse = (hit_ctrl && bad_ctrl) || ((hit_rx || hit_tx) && bad_src)
      || (hit_lag && bad_lag);
   wire wr_ok = wr && !unmapped && !refuse;

   // Zero wait states: read data are latched during the setup cycle.
   assign PREADY = 1'b1;
   assign PSLVERR = acc_ph && (unmapped || (PWRITE && refuse));

   // Control and mirror registers.
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         {loc_q, rem_q, srct_q} <= 3'h0;
         refl_q <= 4'h0;
         dest_q <= 4'h0;
      end else if (wr_ok && hit_ctrl) begin
         loc_q <= PWDATA[`F_LOC];
         rem_q <= PWDATA[`F_REM];
         srct_q <= PWDATA[`F_SRC];
         refl_q <= w_refl;
         dest_q <= w_dest;
      end
   end

   // Remote VLAN, mirror sources, admin state and hash enables.
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         vid_q <= `VID_RST;
         rx_q <= '0;
         tx_q <= '0;
         admin_q <= '1;
         hen_q <= `HASH_RST;
         vlan_q <= '1;
      end else begin
         if (wr_ok && hit_vid) vid_q <= PWDATA[11:0];
         if (wr_ok && hit_rx) rx_q <= wm;
         if (wr_ok && hit_tx) tx_q <= wm;
         if (wr_ok && hit_adm) admin_q <= wm;
         if (wr_ok && hit_hen) hen_q <= PWDATA[5:0];
         if (wr_ok && hit_vl) vlan_q <= wm;
      end
   end

   // Group member sets and active limits, one slot per group.
   for (genvar g = 0; g < G; g++) begin : grp
      always_ff @(posedge CLK) begin
         if (!RESET_N) begin
            lag_q[g] <= '0;
            lim_q[g] <= `LIM_RST;
         end else begin
            if (wr_ok && hit_lag && lag_idx == 3'(g)) lag_q[g] <= wm;
            if (wr_ok && hit_lim) lim_q[g] <= PWDATA[4*g+:4];
         end
      end
      assign pk.mem[g] = lag_q[g];
      assign pk.limit[g] = lim_q[g];
   end
   assign pk.link = PORT_LINK;

   // Refused-write flag; a new refusal wins over a clear in the same cycle.
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         refused_q <= 1'b0;
      end else if (wr && !unmapped && refuse) begin
         refused_q <= 1'b1;
      end else if (wr && hit_st && PWDATA[0]) begin
         refused_q <= 1'b0;
      end
   end

   // Live mirror state; a shut reflector ends remote copies at once.
   wire rem_live = rem_q && srct_q && rok(refl_q);
   wire [N-1:0] refl_bit = ONE << refl_q;
   wire [N-1:0] dest_bit = ONE << dest_q;
   wire [N-1:0] tx_eff = tx_q & ~dest_bit;

   // VLAN membership is widened to whole groups.
   logic [N-1:0] vlan_eff;
   always_comb begin
      vlan_eff = vlan_q;
      for (int g = 0; g < G; g++) begin
         if (|(vlan_q & lag_q[g])) vlan_eff = vlan_eff | lag_q[g];
      end
   end

   // Read mux.
   logic [31:0] st_word, lim_word;
   always_comb begin
      st_word = {31'h0, refused_q};
      st_word[1] = rem_live;
      st_word[2] = loc_q;
      lim_word = 32'h0;
      for (int g = 0; g < G; g++) begin
         st_word[8+g] = |pk.act[g];
         lim_word[4*g+:4] = lim_q[g];
      end
   end
   wire [N-1:0] lag_rd = hit_lag ? lag_q[lag_idx] : '0;
   wire [31:0] rd_mux = hit_ctrl ? {20'h0, dest_q, refl_q, 1'b0, srct_q, rem_q, loc_q}
      : hit_vid ? {20'h0, vid_q}
      : hit_rx ? 32'(rx_q)
      : hit_tx ? 32'(tx_q)
      : hit_adm ? 32'(admin_q)
      : hit_hen ? {26'h0, hen_q}
      : hit_lim ? lim_word
      : hit_st ? st_word
      : hit_vl ? 32'(vlan_eff)
      : 32'(lag_rd);

   always_ff @(posedge CLK) begin
      if (!RESET_N) PRDATA <= 32'h0;
      else if (setup && !PWRITE) PRDATA <= rd_mux;
   end

   // Flow hash and member selection.
   lag_hash u_hash (
      .smac(FRM_SMAC),
      .dmac(FRM_DMAC),
      .sip(FRM_SIP),
      .dip(FRM_DIP),
      .sport(FRM_SPORT),
      .dport(FRM_DPORT),
      .ip4(FRM_IP4),
      .l4(FRM_L4),
      .en(hen_q),
      .pk(pk.hsh)
   );
   lag_pick #(.N(N), .G(G)) u_pick (
      .clk(CLK),
      .rst_n(RESET_N),
      .pk(pk.sel)
   );

   // A group in the destination set collapses to its one picked member.
   logic [N-1:0] dst_l;
   always_comb begin
      dst_l = FRM_DST;
      for (int g = 0; g < G; g++) begin
         if (|(FRM_DST & lag_q[g])) dst_l = (dst_l & ~lag_q[g]) | pk.pick[g];
      end
   end

   // Mirror and reflector decisions for the frame on offer.
   wire acc = FRM_VALID && FRM_READY;
   wire [N-1:0] src_bit = ONE << FRM_SRC;
   wire from_refl = rem_live && (FRM_SRC == refl_q);
   wire [N-1:0] dst_v = dst_l & vlan_eff & ~src_bit & ~(rem_live ? refl_bit : '0);
   wire rx_hit = |(rx_q & src_bit);
   wire tx_hit = |(dst_v & tx_eff);
   wire mir = (rx_hit || tx_hit) && !from_refl;
   wire [N-1:0] cp_v = ((loc_q && mir) ? dest_bit : '0) | ((rem_live && mir) ? refl_bit : '0);

   assign FRM_READY = !OUT_VALID || OUT_READY;

   // One-stage output register; holds while the consumer stalls.
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         OUT_VALID <= 1'b0;
         OUT_DST <= '0;
         OUT_COPY <= '0;
         OUT_TAG <= 1'b0;
         OUT_VID <= 12'h000;
      end else if (acc) begin
         OUT_VALID <= 1'b1;
         OUT_DST <= from_refl ? '0 : dst_v;
         OUT_COPY <= cp_v;
         OUT_TAG <= rem_live && mir;
         OUT_VID <= vid_q;
      end else if (OUT_READY) begin
         OUT_VALID <= 1'b0;
      end
   end

   // Helper views for the checks below.
   logic lag_ovl, lag_big;
   always_comb begin
      lag_ovl = 1'b0;
      lag_big = 1'b0;
      for (int a = 0; a < G; a++) begin
         lag_big = lag_big || ($countones(lag_q[a]) > MAXM);
         for (int b = a + 1; b < G; b++) begin
            lag_ovl = lag_ovl || |(lag_q[a] & lag_q[b]);
         end
      end
   end

   property p_rx_copy;
      @(posedge CLK) disable iff (!RESET_N)
      acc && rx_hit && loc_q && !from_refl |=> OUT_VALID && |(OUT_COPY & $past(dest_bit));
   endproperty
   a_rx_copy: assert property (p_rx_copy) else $error("rx frame not mirrored");

   property p_tx_copy;
      @(posedge CLK) disable iff (!RESET_N)
      acc && tx_hit && rem_live && !from_refl |=> OUT_TAG && (OUT_COPY[$past(refl_q)]);
   endproperty
   a_tx_copy: assert property (p_tx_copy) else $error("tx frame not mirrored");

   property p_refl_excl;
      @(posedge CLK) disable iff (!RESET_N)
      acc && rem_live |=> !OUT_DST[$past(refl_q)];
   endproperty
   a_refl_excl: assert property (p_refl_excl) else $error("normal traffic on reflector");

   property p_refl_down;
      @(posedge CLK) disable iff (!RESET_N)
      acc && !admin_q[refl_q] |=> !OUT_TAG;
   endproperty
   a_refl_down: assert property (p_refl_down) else $error("copy via shut reflector");

   property p_refl_refuse;
      @(posedge CLK) disable iff (!RESET_N)
      wr && hit_ctrl && PWDATA[`F_REM] && !PWDATA[`F_SRC] |-> PSLVERR ##1 refused_q;
   endproperty
   a_refl_refuse: assert property (p_refl_refuse) else $error("bad reflector taken");

   property p_dest_notx;
      @(posedge CLK) disable iff (!RESET_N)
      acc && !rx_hit && !rem_live && (dst_v == dest_bit) |=> OUT_COPY == '0;
   endproperty
   a_dest_notx: assert property (p_dest_notx) else $error("dest tx mirrored");

   property p_one_group;
      @(posedge CLK) disable iff (!RESET_N)
      !lag_ovl && !lag_big;
   endproperty
   a_one_group: assert property (p_one_group) else $error("group overlap or size");

   property p_vid_hold;
      @(posedge CLK) disable iff (!RESET_N)
      !(wr && hit_vid) |=> vid_q == $past(vid_q);
   endproperty
   a_vid_hold: assert property (p_vid_hold) else $error("remote VLAN changed");
endmodule

// >>> design/mlf_defines.svh
`ifndef MLF_DEFINES_SVH
`define MLF_DEFINES_SVH
// Register byte offsets on the APB bus.
`define A_MIR_CTRL 8'h00
`define A_RMIR_VID 8'h04
`define A_MIR_RX 8'h08
`define A_MIR_TX 8'h0C
`define A_ADMIN 8'h10
`define A_HASH_EN 8'h14
`define A_ACT_LIM 8'h18
`define A_STATUS 8'h1C
`define A_VLAN 8'h20
`define A_LAG_BASE 8'h40
// Mirror control field positions.
`define F_LOC 0
`define F_REM 1
`define F_SRC 2
`define F_REFL 4
`define F_DEST 8
// Hash enable bits.
`define H_SMAC 0
`define H_DMAC 1
`define H_SIP 2
`define H_DIP 3
`define H_SPORT 4
`define H_DPORT 5
// Reset values and parameter defaults.
`define VID_RST 12'h0C8
`define HASH_RST 6'h3D
`define LIM_RST 4'hA
`define MAXM_DEF 10
`define NGRP_DEF 5
`endif

// >>> design/mlf_pkg.sv
package mlf_pkg;
   typedef logic [11:0] vid_t;
   typedef logic [3:0] pidx_t;
   typedef logic [7:0] hash_t;
   typedef logic [5:0] hsel_t;
endpackage

// >>> sim/frame_sink.sv
`timescale 1ns/10ps
module frame_sink #(parameter int N = 12) (
   // Clock, reset and stall request
   input wire logic clk,
   input wire logic rst_n,
   input wire logic stall,
   // Decision stream from the forwarding block
   input wire logic valid,
   output logic ready,
   input wire logic [N-1:0] dst,
   input wire logic [N-1:0] copy,
   input wire logic tag,
   input wire mlf_pkg::vid_t vid,
   // Last decision taken and how many so far
   output logic [N-1:0] got_dst,
   output logic [N-1:0] got_copy,
   output logic got_tag,
   output mlf_pkg::vid_t got_vid,
   output int got_n
);
   // Ready follows the stall request, so decisions are taken at once or after a wait.
   assign ready = !stall;

   // A decision counts only at an edge where it is both offered and accepted.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         got_n <= 0;
      end else if (valid && ready) begin
         got_dst <= dst;
         got_copy <= copy;
         got_tag <= tag;
         got_vid <= vid;
         got_n <= got_n + 1;
      end
   end
endmodule

// >>> sim/tb.sv
`timescale 1ns/10ps
`include "mlf_defines.svh"
module tb;
   logic clk, rst_n, psel, pen, pwr, stall, fvalid, ip4, l4;
   logic pready, pslverr, perr, frdy, ovalid, oready, otag, gtag;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [31:0] s = 32'h43, t = 32'h43;
   logic [63:0] q;
   logic [11:0] link, fdx, cop, learn, stp, fdst, odst, ocopy, gdst, gcopy, m;
   logic [23:0] speed;
   logic [3:0] fsrc;
   logic [47:0] smac, dmac;
   logic [31:0] sip, dip;
   logic [15:0] sport, dport;
   mlf_pkg::vid_t ovid, gvid;
   int gn, errors, checked;

   // Small group limit so the oversize refusal is reachable with twelve ports.
   mirror_lag_fwd #(.N(12), .G(5), .MAXM(3)) mirror_lag_fwd_i (.CLK(clk), .RESET_N(rst_n),
      .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PORT_LINK(link),
      .PORT_FDX(fdx), .PORT_COPPER(cop), .PORT_LEARN(learn), .PORT_STP(stp),
      .PORT_SPEED(speed), .FRM_VALID(fvalid), .FRM_READY(frdy), .FRM_SRC(fsrc),
      .FRM_DST(fdst), .FRM_SMAC(smac), .FRM_DMAC(dmac), .FRM_SIP(sip), .FRM_DIP(dip),
      .FRM_SPORT(sport), .FRM_DPORT(dport), .FRM_IP4(ip4), .FRM_L4(l4),
      .OUT_VALID(ovalid), .OUT_READY(oready), .OUT_DST(odst), .OUT_COPY(ocopy),
      .OUT_TAG(otag), .OUT_VID(ovid));

   frame_sink #(.N(12)) frame_sink_i (.clk(clk), .rst_n(rst_n), .stall(stall),
      .valid(ovalid), .ready(oready), .dst(odst), .copy(ocopy), .tag(otag), .vid(ovid),
      .got_dst(gdst), .got_copy(gcopy), .got_tag(gtag), .got_vid(gvid), .got_n(gn));

   // Free-running clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Fixed-seed generator; each process owns its state, so no two race on one seed.
   function automatic logic [31:0] xs(ref logic [31:0] st);
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction

   // Expected control word from mode bits, reflector and mirror destination.
   function automatic logic [31:0] ctrl(input logic [2:0] md, input logic [3:0] r,
      input logic [3:0] d);
      return {20'h0, d, r, 1'b0, md};
   endfunction

   // Expected member: byte XOR fold of the flow fields, modulo the live member count.
   // It assumes every hash field is enabled and the active limit covers the group.
   function automatic logic [11:0] exp_pick(input logic [11:0] mem, input logic [11:0] up);
      logic [191:0] key;
      logic [7:0] h;
      int n;
      int j;
      key = {smac, dmac, ip4 ? {sip, dip} : 64'h0, l4 ? {sport, dport} : 32'h0};
      h = 8'h00;
      n = $countones(mem & up);
      j = 0;
      exp_pick = 12'h000;
      for (int i = 0; i < 24; i++) begin
         h = h ^ key[8*i+:8];
      end
      for (int i = 0; i < 12; i++) begin
         if (mem[i] && up[i]) begin
            if (j == int'(h) % n) exp_pick[i] = 1'b1;
            j++;
         end
      end
   endfunction

   // The sink stalls about one cycle in four to exercise held decisions.
   always @(posedge clk) stall <= (xs(t) & 32'h3) == 32'h0;

   task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // Offers one frame and waits, bounded, until the sink has taken its decision.
   task automatic frm(input logic [3:0] sp, input logic [11:0] d);
      int n0;
      int k;
      n0 = gn;
      @(posedge clk);
      fvalid <= 1'b1;
      fsrc <= sp;
      fdst <= d;
      do @(posedge clk); while (frdy !== 1'b1);
      fvalid <= 1'b0;
      for (k = 0; k < 60 && gn == n0; k++) begin
         @(posedge clk);
         #1;
      end
      if (gn == n0) chk("decision", 0, 1);
   endtask

   task stop_test();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Cuts a hang short well beyond the few hundred cycles the tests need.
   initial begin
      #200000;
      errors++;
      stop_test();
   end

   initial begin
      {psel, pen, pwr, fvalid, ip4, l4, rst_n} = '0;
      {paddr, pwdata, fsrc, fdst, smac, dmac, sip, dip, sport, dport} = '0;
      {link, fdx, cop} = {3{12'hFFF}};
      {learn, stp} = {2{12'hFBF}};
      speed = {12{2'b10}};
      errors = 0;
      checked = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      apb(0, `A_RMIR_VID, 0);
      chk("vid", rd, 32'h0C8);
      apb(0, 8'h3C, 0);
      chk("unmapped", perr, 1);
      $display("test reset done");
      apb(1, `A_MIR_CTRL, ctrl(3'h1, 0, 5));
      apb(1, `A_MIR_RX, 32'h004);
      apb(1, `A_MIR_TX, 32'h0A0);
      frm(2, 12'h00C);
      chk("dst", gdst, 12'h008);
      chk("copy", gcopy, 12'h020);
      frm(1, 12'h080);
      chk("copy", gcopy, 12'h020);
      frm(1, 12'h020);
      chk("copy", gcopy, 12'h000);
      $display("test local done");
      apb(1, `A_RMIR_VID, 32'h123);
      apb(1, `A_MIR_CTRL, ctrl(3'h7, 6, 5));
      chk("err", perr, 0);
      frm(2, 12'h048);
      chk("dst", gdst, 12'h008);
      chk("copy", gcopy, 12'h060);
      chk("tag", gtag, 1);
      chk("vid", gvid, 12'h123);
      apb(1, `A_MIR_CTRL, ctrl(3'h6, 6, 5));
      frm(2, 12'h008);
      chk("copy", gcopy, 12'h040);
      frm(6, 12'h008);
      chk("dst", gdst, 12'h000);
      apb(1, `A_MIR_CTRL, ctrl(3'h7, 7, 5));
      chk("err", perr, 1);
      apb(1, `A_MIR_CTRL, ctrl(3'h3, 6, 5));
      chk("err", perr, 1);
      apb(0, `A_MIR_CTRL, 0);
      chk("ctrl", rd, ctrl(3'h6, 6, 5));
      apb(1, `A_ADMIN, 32'hFBF);
      frm(2, 12'h008);
      chk("copy", gcopy, 12'h000);
      chk("tag", gtag, 0);
      apb(1, `A_MIR_CTRL, ctrl(3'h7, 6, 5));
      chk("err", perr, 1);
      apb(1, `A_ADMIN, 32'hFFF);
      apb(1, `A_MIR_CTRL, ctrl(3'h1, 0, 5));
      frm(1, 12'h040);
      chk("dst", gdst, 12'h040);
      $display("test remote done");
      apb(1, `A_HASH_EN, 0);
      apb(1, `A_ACT_LIM, 32'hAAAA1);
      apb(1, `A_LAG_BASE, 32'h700);
      chk("err", perr, 0);
      frm(0, 12'h200);
      chk("dst", gdst, 12'h100);
      link <= 12'hEFF;
      frm(0, 12'h200);
      chk("dst", gdst, 12'h200);
      link <= 12'hFFF;
      apb(1, `A_LAG_BASE + 8'h4, 32'h300);
      chk("err", perr, 1);
      apb(1, `A_LAG_BASE + 8'h4, 32'h020);
      chk("err", perr, 1);
      apb(1, `A_LAG_BASE + 8'h4, 32'h004);
      chk("err", perr, 1);
      apb(1, `A_MIR_RX, 32'h204);
      chk("err", perr, 1);
      apb(1, `A_LAG_BASE + 8'h4, 32'h80B);
      chk("err", perr, 1);
      speed[23:22] <= 2'b01;
      apb(1, `A_LAG_BASE + 8'h4, 32'h802);
      chk("err", perr, 1);
      speed[23:22] <= 2'b10;
      fdx[11] <= 1'b0;
      apb(1, `A_LAG_BASE + 8'h4, 32'h802);
      chk("err", perr, 1);
      fdx[11] <= 1'b1;
      apb(1, `A_LAG_BASE + 8'h4, 32'h802);
      chk("err", perr, 0);
      apb(0, `A_STATUS, 0);
      chk("status", rd, 32'h305);
      apb(1, `A_STATUS, 1);
      apb(0, `A_STATUS, 0);
      chk("status", rd, 32'h304);
      apb(1, `A_VLAN, 32'h400);
      apb(0, `A_VLAN, 0);
      chk("vlan", rd, 32'h700);
      frm(0, 12'h200);
      chk("dst", gdst, 12'h100);
      apb(1, `A_VLAN, 32'hFFF);
      $display("test groups done");
      apb(1, `A_HASH_EN, 32'h3F);
      apb(1, `A_ACT_LIM, 32'hAAAAA);
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         q = {xs(s), xs(s)};
         smac <= q[47:0];
         dmac <= q[63:16];
         q = {xs(s), xs(s)};
         sip <= q[31:0];
         dip <= q[63:32];
         q = {xs(s), xs(s)};
         sport <= q[15:0];
         dport <= q[31:16];
         ip4 <= q[32];
         l4 <= q[33];
         frm(0, 12'h200);
         m = gdst;
         chk("member", m, exp_pick(12'h700, 12'hFFF));
         frm(0, 12'h200);
         chk("same", gdst, m);
         link <= ~m;
         frm(0, 12'h200);
         chk("moved", gdst, exp_pick(12'h700, ~m));
         link <= 12'hFFF;
      end
      $display("test flows done");
      stop_test();
   end
endmodule
